/* File: rtl/lccc_core.sv */
`timescale 1ns/10ps
`default_nettype none
`include "lccc_map.svh"
module lccc_core
  import lccc_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic disable_pin,
  input wire logic bias_limit_sense,
  input wire logic data_in_p,
  output logic currentsOn,
  output logic [8:0] biasDrive,
  output logic [8:0] modDrive,
  output logic [5:0] deemphAmountOut,
  output logic [1:0] deemphModeOut,
  output logic eqEnableOut,
  output logic [1:0] eqSelectOut,
  output logic outputInvertOut,
  output logic laser_drive_out_p,
  output logic laser_drive_out_n,
  output logic faultOut,
  output logic faultOe
);
  // ************************************************************
  // pin synchronisers and state
  // ************************************************************
  typedef struct packed {
    lccc_regs_s regs;
    logic dis;
    logic fault;
    logic dat;
    logic act;
    logic [7:0] actCnt;
  } lccc_state_s;
  lccc_state_s st_r, st_nxt;
  logic [2:0] pins;
  logic disS, senseS, dataS;
  logic req, wr, wrOk, clrAll, toggle;
  lccc_chan_s bias, modc;
  logic [9:0] deSub;
  logic [8:0] modEff;
  lccc_sync u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .ce(ce),
    .din({disable_pin, bias_limit_sense, data_in_p}),
    .dout(pins)
  );
  assign disS = pins[2];
  assign senseS = pins[1];
  assign dataS = pins[0];
  assign req = wb_cyc_i && wb_stb_i && !st_r.regs.ack;
  assign wr = req && wb_we_i && wb_sel_i[0];
  // ************************************************************
  // write gating
  // ************************************************************
  // protects laser: codes and limits writable only in open mode
  assign wrOk = wr && st_r.regs.modeCtl[`LCCC_B_OPEN];
  // disable toggle: falling edge of the synced pin closes the toggle
  assign toggle = st_r.dis && !disS;
  assign clrAll = toggle && !senseS;
  lccc_step_chan u_bias (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .ce(ce),
    .loadUpper(wrOk && wb_adr_i == `LCCC_A_BIAS),
    .upperVal(wb_dat_i[7:0]),
    .loadLimit(wrOk && wb_adr_i == `LCCC_A_BLIM),
    .limitVal(wb_dat_i[7:0]),
    .stepStb(wr && wb_adr_i == `LCCC_A_BSTEP),
    .stepVal(wb_dat_i[7:0]),
    .clrWarn(toggle),
    .chan(bias)
  );
  lccc_step_chan u_mod (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .ce(ce),
    .loadUpper(wrOk && wb_adr_i == `LCCC_A_MOD),
    .upperVal(wb_dat_i[7:0]),
    .loadLimit(wrOk && wb_adr_i == `LCCC_A_MLIM),
    .limitVal(wb_dat_i[7:0]),
    .stepStb(wr && wb_adr_i == `LCCC_A_MSTEP),
    .stepVal(wb_dat_i[7:0]),
    .clrWarn(toggle),
    .chan(modc)
  );
  // ************************************************************
  // register file and status logic
  // ************************************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.dis = disS;
    st_nxt.dat = dataS;
    st_nxt.regs.ack = req;
    // activity: any edge within a window of cycles
    if (dataS != st_r.dat) begin
      st_nxt.actCnt = `LCCC_ACT_WIN;
      st_nxt.act = 1'b1;
    end else if (st_r.actCnt != 8'h00) begin
      st_nxt.actCnt = st_r.actCnt - 8'h01;
    end else begin
      st_nxt.act = 1'b0;
    end
    // set wins over clear: sense high keeps the latch
    if (clrAll) st_nxt.fault = 1'b0;
    if (senseS) st_nxt.fault = 1'b1;
    if (wr && wb_adr_i == `LCCC_A_MODE) st_nxt.regs.modeCtl = wb_dat_i[7:0];
    if (wrOk && wb_adr_i == `LCCC_A_TRANSMIT_CONTROL) st_nxt.regs.transmit_control = wb_dat_i[7:0];
    if (wrOk && wb_adr_i == `LCCC_A_EQSEL) st_nxt.regs.eqsel = wb_dat_i[7:0];
    if (wrOk && wb_adr_i == `LCCC_A_DEAMT) st_nxt.regs.deAmt = wb_dat_i[5:0];
    st_nxt.regs.dat = 32'h0000_0000;
    if (req && !wb_we_i) begin
      case (wb_adr_i)
        `LCCC_A_TRANSMIT_CONTROL: st_nxt.regs.dat = {24'h000000, st_r.regs.transmit_control};
        `LCCC_A_BIAS: st_nxt.regs.dat = {24'h000000, bias.code[8:1]};
        `LCCC_A_MOD: st_nxt.regs.dat = {24'h000000, modc.code[8:1]};
        `LCCC_A_BLIM: st_nxt.regs.dat = {24'h000000, bias.limit};
        `LCCC_A_MLIM: st_nxt.regs.dat = {24'h000000, modc.limit};
        `LCCC_A_EQSEL: st_nxt.regs.dat = {24'h000000, st_r.regs.eqsel};
        `LCCC_A_DEAMT: st_nxt.regs.dat = {26'h0000000, st_r.regs.deAmt};
        `LCCC_A_STATUS: st_nxt.regs.dat = {28'h0000000, st_r.fault, modc.warn,
          bias.warn, st_r.act};
        `LCCC_A_MODE: st_nxt.regs.dat = {24'h000000, st_r.regs.modeCtl};
        default: st_nxt.regs.dat = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
      st_r.dis <= 1'b1;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end
  // ************************************************************
  // drive outputs
  // ************************************************************
  // deemphasis removes deAmt/64 of the modulation code
  assign deSub = 10'((15'(modc.code) * 15'(st_r.regs.deAmt)) >> 6);
  assign modEff = modc.code - deSub[8:0];
  // reset, disable or fault kill both currents
  assign currentsOn = !sys_rst && !st_r.dis && !st_r.fault;
  assign biasDrive = currentsOn ? bias.code : 9'h000;
  assign modDrive = currentsOn ? modEff : 9'h000;
  assign deemphModeOut = st_r.regs.transmit_control[`LCCC_B_DEM_HI:`LCCC_B_DEM_LO];
  assign deemphAmountOut = st_r.regs.deAmt;
  assign eqEnableOut = st_r.regs.transmit_control[`LCCC_B_EQEN];
  assign eqSelectOut = eqEnableOut ?
    st_r.regs.eqsel[`LCCC_B_EQ_HI:`LCCC_B_EQ_LO] : 2'h0;
  assign outputInvertOut = st_r.regs.transmit_control[`LCCC_B_INV];
  assign laser_drive_out_p = currentsOn && (st_r.dat ^ outputInvertOut);
  assign laser_drive_out_n = currentsOn && !(st_r.dat ^ outputInvertOut);
  assign faultOut = 1'b0;
  assign faultOe = !st_r.fault; // open drain: released means high
  assign wb_ack_o = st_r.regs.ack;
  assign wb_dat_o = st_r.regs.dat;
  // ************************************************************
  // checks
  // ************************************************************
  fault_latch_a: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && senseS |=> !faultOe)
    else $error("fault not latched");
  fault_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
    st_r.fault && !(ce && clrAll) |=> st_r.fault)
    else $error("fault released early");
  disable_off_a: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && disS |=> biasDrive == 9'h000 && modDrive == 9'h000
    && !laser_drive_out_p && !laser_drive_out_n)
    else $error("current on while disabled");
  eq_gate_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !eqEnableOut |-> eqSelectOut == 2'h0)
    else $error("eq select leaked");
  lock_code_a: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && !st_r.regs.modeCtl[`LCCC_B_OPEN] && !(wr && (wb_adr_i == `LCCC_A_BSTEP))
    |=> $stable(bias.code))
    else $error("bias code changed while locked");
  mod_lock_a: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && !st_r.regs.modeCtl[`LCCC_B_OPEN] && !(wr && (wb_adr_i == `LCCC_A_MSTEP))
    |=> $stable(modc.code))
    else $error("mod code changed while locked");
  limit_lock_a: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && !st_r.regs.modeCtl[`LCCC_B_OPEN] |=> $stable(bias.limit) && $stable(modc.limit)
    && $stable(st_r.regs.transmit_control))
    else $error("setting changed while locked");
  ack_once_a: assert property (@(posedge mclk) disable iff (sys_rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  ack_answer_a: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && req |=> wb_ack_o)
    else $error("request not acked");
  act_set_a: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && dataS != st_r.dat |=> st_r.act)
    else $error("activity missed");
  fault_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && clrAll |=> faultOe)
    else $error("fault not cleared");
endmodule // lccc_core
`default_nettype wire

/* File: rtl/lccc_map.svh */
// Operation
// - bias code upper bits loaded by write
// - bias lsb reset zero, changed by step
// - bias limit caps upper code bits
// - bias step: leading five bits signed
// - bias overflow sets warning, code kept
// - mod code upper bits loaded by write
// - mod lsb reset zero, changed by step
// - mod limit caps upper code bits
// - mod step: leading five bits signed
// - mod overflow sets warning, code kept
// - drive equals mod code minus deemphasis
// - deemphasis mode bits 5:4, amount six bits
// - eq enable bit 3 gates select bits
// - invert bit flips drive sense
// - status bit shows input activity
// - reset: currents off, registers default
// - sense over threshold latches fault
// - fault held until cleared by disable toggle
// - disable high turns currents off
// - normal mode: only step and mode registers writable
`ifndef LCCC_MAP_SVH
`define LCCC_MAP_SVH
// ************************************************************
// register byte addresses
// ************************************************************
`define LCCC_A_TRANSMIT_CONTROL 8'h00
`define LCCC_A_BIAS 8'h04
`define LCCC_A_MOD 8'h08
`define LCCC_A_BLIM 8'h0C
`define LCCC_A_MLIM 8'h10
`define LCCC_A_BSTEP 8'h14
`define LCCC_A_MSTEP 8'h18
`define LCCC_A_EQSEL 8'h1C
`define LCCC_A_DEAMT 8'h20
`define LCCC_A_STATUS 8'h24
`define LCCC_A_MODE 8'h28
// ************************************************************
// fields and defaults
// ************************************************************
`define LCCC_B_INV 0
`define LCCC_B_EQEN 3
`define LCCC_B_DEM_LO 4
`define LCCC_B_DEM_HI 5
`define LCCC_B_EQ_LO 1
`define LCCC_B_EQ_HI 2
`define LCCC_B_STEP_HI 7
`define LCCC_B_STEP_LO 3
`define LCCC_B_ACT 0
`define LCCC_B_BWARN 1
`define LCCC_B_MWARN 2
`define LCCC_B_FAULT 3
`define LCCC_B_OPEN 0
`define LCCC_RST_CODE 9'h000
`define LCCC_RST_LIM 8'hFF
`define LCCC_RST_BYTE 8'h00
`define LCCC_RST_AMT 6'h00
`define LCCC_ACT_WIN 8'hFF
// sync flops start at pin idle levels {disable high, sense low, data low}
// so no false fault or activity edge follows reset
`define LCCC_RST_SYNC 3'h4
`endif

/* File: rtl/lccc_pkg.sv */
package lccc_pkg;
  typedef struct packed {
    logic [8:0] code;
    logic [7:0] limit;
    logic warn;
  } lccc_chan_s;
  typedef struct packed {
    logic [7:0] transmit_control;
    logic [7:0] eqsel;
    logic [5:0] deAmt;
    logic [7:0] modeCtl;
    logic ack;
    logic [31:0] dat;
  } lccc_regs_s;
endpackage

/* File: rtl/lccc_step_chan.sv */
`timescale 1ns/10ps
`default_nettype none
`include "lccc_map.svh"
module lccc_step_chan
  import lccc_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic loadUpper,
  input wire logic [7:0] upperVal,
  input wire logic loadLimit,
  input wire logic [7:0] limitVal,
  input wire logic stepStb,
  input wire logic [7:0] stepVal,
  input wire logic clrWarn,
  output lccc_chan_s chan
);
  lccc_chan_s st_r, st_nxt;
  logic [9:0] sum;
  always_comb begin
    st_nxt = st_r;
    sum = {1'b0, st_r.code} + {{5{stepVal[`LCCC_B_STEP_HI]}},
      stepVal[`LCCC_B_STEP_HI:`LCCC_B_STEP_LO]};
    if (clrWarn) st_nxt.warn = 1'b0;
    if (loadLimit) st_nxt.limit = limitVal;
    if (loadUpper) st_nxt.code = {upperVal, st_r.code[0]};
    else if (stepStb) begin
      // carry out or negative wrap also counts as exceeding
      if (sum[9] || sum[8:1] > st_r.limit) st_nxt.warn = 1'b1;
      else st_nxt.code = sum[8:0];
    end
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '{code: `LCCC_RST_CODE, limit: `LCCC_RST_LIM, warn: 1'b0};
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end
  assign chan = st_r;
  step_kept_a: assert property (@(posedge mclk) disable iff (sys_rst)
    ce && stepStb && !loadUpper && sum[8:1] > st_r.limit |=> chan.warn && $stable(chan.code))
    else $error("overflow step changed code");
  warn_sticky_a: assert property (@(posedge mclk) disable iff (sys_rst)
    chan.warn && !(ce && clrWarn) |=> chan.warn)
    else $error("warning dropped");
endmodule // lccc_step_chan
`default_nettype wire

/* File: rtl/lccc_sync.sv */
`timescale 1ns/10ps
`default_nettype none
`include "lccc_map.svh"
module lccc_sync (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [2:0] din,
  output logic [2:0] dout
);
  logic [2:0] s1_r, s2_r;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_r <= `LCCC_RST_SYNC;
      s2_r <= `LCCC_RST_SYNC;
    end else if (ce) begin
      s1_r <= din;
      s2_r <= s1_r;
    end
  end
  assign dout = s2_r;
endmodule // lccc_sync
`default_nettype wire

/* File: testbench/lccc_wb_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ****************
// register master
// ****************
// holds every request until ack is sampled high, no fixed latency assumed
module lccc_wb_model (
  input wire logic mclk,
  input wire logic ack,
  input wire logic [31:0] datI,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [7:0] adr,
  output logic [3:0] sel,
  output logic [31:0] dat
);
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    dat <= d;
    @(posedge mclk);
    while (ack !== 1'b1) @(posedge mclk);
    q = datI;
    cyc <= 1'b0;
    stb <= 1'b0;
    dat <= ~d;
    @(posedge mclk);
  endtask
endmodule // lccc_wb_model
`default_nettype wire

/* File: testbench/tb_laser_current_code_control.sv */
`timescale 1ns/10ps
`default_nettype none
`include "lccc_map.svh"
module tb_laser_current_code_control;
  import lccc_pkg::*;
  logic mclk = 1'b0;
  logic sysRst = 1'b1;
  logic disPin = 1'b1;
  logic sense = 1'b0;
  logic dIn = 1'b0;
  logic ce = 1'b1;
  logic cyc, stb, we, ack, curOn, eqEn, inv, outP, outN, fOut, fOe;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  logic [8:0] bDrv, mDrv;
  logic [5:0] deAmt;
  logic [1:0] deMode, eqSel;
  int n_errors = 0;
  int checked = 0;
  always #20 mclk = ~mclk;
  lccc_wb_model lccc_wb_model_inst (.mclk(mclk), .ack(ack), .datI(rdat), .cyc(cyc),
    .stb(stb), .we(we), .adr(adr), .sel(sel), .dat(wdat));
  lccc_core lccc_core_inst (.mclk(mclk), .sys_rst(sysRst), .ce(ce), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .disable_pin(disPin), .bias_limit_sense(sense),
    .data_in_p(dIn), .currentsOn(curOn), .biasDrive(bDrv), .modDrive(mDrv),
    .deemphAmountOut(deAmt), .deemphModeOut(deMode), .eqEnableOut(eqEn),
    .eqSelectOut(eqSel), .outputInvertOut(inv), .laser_drive_out_p(outP),
    .laser_drive_out_n(outN), .faultOut(fOut), .faultOe(fOe));
  // ****************
  // helpers
  // ****************
  task automatic end_of_test;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    lccc_wb_model_inst.xfer(1'b1, a, {24'h0, d}, q);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e,
                    input logic [7:0] m);
    logic [31:0] q;
    lccc_wb_model_inst.xfer(1'b0, a, 32'h0, q);
    chk(nm, {24'h0, e & m}, q & {24'h0, m});
  endtask
  // toggle also clears sticky flags; sync delay is two flops plus edge detect
  task automatic toggleDis;
    disPin <= 1'b1;
    repeat (6) @(posedge mclk);
    chk("drvOff", 32'h0, {11'h0, outP, outN, curOn, bDrv, mDrv});
    disPin <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask
  // returns {warn, code}; a step that leaves 0..511 counts as exceeding
  function automatic logic [9:0] stepModel(input logic [8:0] c, input logic [7:0] lim,
                                           input logic [7:0] s);
    int n;
    n = int'(c) + int'($signed(s[7:3]));
    if (n < 0 || n > 511 || (n >> 1) > int'(lim)) return {1'b1, c};
    return {1'b0, n[8:0]};
  endfunction
  // ****************
  // main sequence
  // ****************
  initial begin
    logic [9:0] r;
    logic [8:0] bc;
    logic [8:0] mc;
    logic [7:0] s, t, e;
    logic bw, mw;
    logic [7:0] corner [4];
    corner = '{8'h38, 8'hC0, 8'h18, 8'h3F};
    bc = 9'h000;
    mc = 9'h000;
    bw = 1'b0;
    mw = 1'b0;
    void'($urandom(32'h0491));
    repeat (5) @(posedge mclk);
    sysRst <= 1'b0;
    disPin <= 1'b0;
    @(posedge mclk);
    rd("blim", `LCCC_A_BLIM, 8'hFF, 8'hFF);
    rd("mlim", `LCCC_A_MLIM, 8'hFF, 8'hFF);
    wr(`LCCC_A_BIAS, 8'h55);
    rd("biasRo", `LCCC_A_BIAS, 8'h00, 8'hFF);
    wr(`LCCC_A_MODE, 8'h01);
    wr(`LCCC_A_BIAS, 8'h10);
    wr(`LCCC_A_MOD, 8'h10);
    wr(`LCCC_A_BLIM, 8'h12);
    wr(`LCCC_A_MLIM, 8'h14);
    bc = 9'h020;
    mc = 9'h020;
    rd("bias", `LCCC_A_BIAS, 8'h10, 8'hFF);
    rd("mod", `LCCC_A_MOD, 8'h10, 8'hFF);
    for (int i = 0; i < 60; i++) begin
      s = (i < 4) ? corner[i] : {5'($urandom_range(0, 15)) - 5'h08, 3'($urandom)};
      if (i % 2 == 1) begin
        r = stepModel(mc, 8'h14, s);
        wr(`LCCC_A_MSTEP, s);
        mc = r[8:0];
        mw |= r[9];
      end else begin
        r = stepModel(bc, 8'h12, s);
        wr(`LCCC_A_BSTEP, s);
        bc = r[8:0];
        bw |= r[9];
      end
      chk("bDrv", 32'(bc), 32'(bDrv));
      chk("mDrv", 32'(mc), 32'(mDrv));
      rd("warn", `LCCC_A_STATUS, {5'h0, mw, bw, 1'b0}, 8'h06);
      if (bw && mw) begin
        toggleDis;
        bw = 1'b0;
        mw = 1'b0;
      end
    end
    wr(`LCCC_A_DEAMT, 8'h20);
    chk("deAmt", 32'h20, 32'(deAmt));
    chk("mDrvDe", 32'(int'(mc) - int'(mc) * 32 / 64), 32'(mDrv));
    for (int i = 0; i < 8; i++) begin
      t = 8'($urandom);
      e = 8'($urandom);
      wr(`LCCC_A_TRANSMIT_CONTROL, t);
      wr(`LCCC_A_EQSEL, e);
      chk("deMode", 32'(t[5:4]), 32'(deMode));
      chk("eq", {29'h0, t[3], (t[3] ? e[2:1] : 2'b00)}, {29'h0, eqEn, eqSel});
      chk("inv", 32'(t[0]), 32'(inv));
    end
    repeat (12) begin
      @(posedge mclk);
      dIn <= ~dIn;
    end
    rd("act", `LCCC_A_STATUS, 8'h01, 8'h01);
    repeat (300) @(posedge mclk);
    rd("idle", `LCCC_A_STATUS, 8'h00, 8'h01);
    chk("drvPol", {30'h0, dIn ^ t[0], ~(dIn ^ t[0])}, {30'h0, outP, outN});
    // clock enable low: a sense pulse meanwhile must not reach the latch
    ce <= 1'b0;
    sense <= 1'b1;
    repeat (6) @(posedge mclk);
    sense <= 1'b0;
    repeat (2) @(posedge mclk);
    ce <= 1'b1;
    repeat (6) @(posedge mclk);
    rd("ceHold", `LCCC_A_STATUS, 8'h00, 8'h08);
    sense <= 1'b1;
    repeat (6) @(posedge mclk);
    sense <= 1'b0;
    repeat (6) @(posedge mclk);
    rd("fault", `LCCC_A_STATUS, 8'h08, 8'h08);
    chk("faultPin", 32'h0, {29'h0, fOut, fOe, curOn});
    toggleDis;
    rd("fltClr", `LCCC_A_STATUS, 8'h00, 8'h08);
    chk("faultOe", 32'h1, 32'(fOe));
    sysRst <= 1'b1;
    @(posedge mclk);
    chk("rstOff", 32'h0, {11'h0, outP, outN, curOn, bDrv, mDrv});
    sysRst <= 1'b0;
    @(posedge mclk);
    rd("biasRst", `LCCC_A_BIAS, 8'h00, 8'hFF);
    end_of_test;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    end_of_test;
  end
endmodule // tb_laser_current_code_control
`default_nettype wire
